/* verilog/ssfs_defs.vh */
// Purpose: shared constants of the frame sequencer
// Assumes: included by bare name from the sequencer source
// Notes: definitions only, no logic
`ifndef SSFS_DEFS_VH
`define SSFS_DEFS_VH

// ----------------------------------------------------------------
// word and buffer geometry
// ----------------------------------------------------------------
`define SSFS_WORD_W 16
`define SSFS_FIFO_DEPTH 8
`define SSFS_FIFO_AW 3

// ----------------------------------------------------------------
// frame formats
// ----------------------------------------------------------------
`define SSFS_FMT_SPI 1'b0
`define SSFS_FMT_CW 1'b1

// ----------------------------------------------------------------
// control-word format geometry
// ----------------------------------------------------------------
`define SSFS_CW_CTRL_BITS 5'h8
`define SSFS_CW_WAIT_BITS 5'h1
`define SSFS_CW_LAST_CTRL_EDGE 6'h0E

// ----------------------------------------------------------------
// master sequencer states
// ----------------------------------------------------------------
`define SSFS_ST_IDLE 3'h0
`define SSFS_ST_PRE 3'h1
`define SSFS_ST_SHIFT 3'h2
`define SSFS_ST_TAIL 3'h3
`define SSFS_ST_GAP 3'h4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SSFS_RST_WORD 16'h0000
`define SSFS_RST_DIV 8'h00

`endif

/* verilog/ssfs_sequencer.v */
// Purpose: frame sequencer of a synchronous serial port, master or slave
// Assumes: control ports are quasi-static while ENABLE is high
// Notes: serial pins from outside pass two flops before any logic reads them
`timescale 1ns/100ps
`default_nettype none
`include "ssfs_defs.vh"

// ----------------------------------------------------------------
// transmit buffer
// ----------------------------------------------------------------
module ssfs_fifo #(
	parameter W = `SSFS_WORD_W,
	parameter D = `SSFS_FIFO_DEPTH,
	parameter AW = `SSFS_FIFO_AW
) (
	input wire clk,
	input wire nrst,
	input wire [W-1:0] in_data,
	input wire in_valid,
	output reg in_ready_r,
	output wire [W-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [W-1:0] mem [0:D-1]; // word storage
	reg [AW-1:0] wp_r; // write pointer
	reg [AW-1:0] rp_r; // read pointer
	reg [AW:0] cnt_r; // words held
	wire push = in_valid & in_ready_r; // accepted write
	wire pop = out_valid & out_ready; // accepted read
	wire [AW:0] cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

	assign out_data = mem[rp_r];
	assign out_valid = (cnt_r != {(AW+1){1'b0}});

	// pointers and fill count; ready is registered from the next count
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wp_r <= {AW{1'b0}};
			rp_r <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
			in_ready_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			in_ready_r <= (cnt_nxt != D[AW:0]);
			if (push) begin
				wp_r <= (wp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= (rp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
			end
		end
	end

	// storage has no reset; only written words are ever read
	always @(posedge clk) begin
		if (push) begin
			mem[wp_r] <= in_data;
		end
	end
endmodule // ssfs_fifo

// ----------------------------------------------------------------
// sequencer top
// ----------------------------------------------------------------
module ssfs_sequencer #(
	parameter DW = 8 // width of the half-period divider
) (
	input wire CLK,
	input wire NRST,
	input wire ENABLE,
	input wire MASTER,
	input wire FORMAT,
	input wire CLOCK_POLARITY_BIT,
	input wire CLOCK_PHASE_BIT,
	input wire [3:0] DATA_SIZE,
	input wire [DW-1:0] HALF_DIV,
	input wire [15:0] TX_DATA,
	input wire TX_VALID,
	output wire TX_READY,
	output reg [15:0] RX_DATA,
	output reg RX_VALID,
	input wire RX_READY,
	output reg BUSY,
	input wire SERIAL_CLOCK_LINE_I,
	output reg SERIAL_CLOCK_LINE_O,
	output reg SERIAL_CLOCK_LINE_OE,
	input wire FRAME_SELECT_LINE_I,
	output reg FRAME_SELECT_LINE_O,
	output reg FRAME_SELECT_LINE_OE,
	output reg TX_DATA_LINE_O,
	output reg TX_DATA_LINE_OE,
	input wire RX_DATA_LINE_I
);
	// ------------------------------------------------------------
	// edge role decode, shared by master and slave
	// ------------------------------------------------------------
	// capture on this edge index
	function cap_f(input cw, input cpha, input slv, input [5:0] e);
		reg [4:0] k;
		begin
			k = e[5:1];
			if (!cw)
				cap_f = (e[0] == cpha);
			else if (slv)
				cap_f = !e[0] && (k < `SSFS_CW_CTRL_BITS);
			else
				cap_f = !e[0] && (k >= `SSFS_CW_CTRL_BITS + `SSFS_CW_WAIT_BITS);
		end
	endfunction

	// launch on this edge index
	function lau_f(input cw, input cpha, input slv, input [5:0] e, input [4:0] n);
		reg [4:0] k;
		begin
			k = e[5:1];
			if (!cw)
				lau_f = (e[0] != cpha);
			else if (slv)
				lau_f = e[0] && (k >= `SSFS_CW_CTRL_BITS) && (k < `SSFS_CW_CTRL_BITS + n);
			else
				lau_f = e[0] && (k < `SSFS_CW_CTRL_BITS - 5'h1);
		end
	endfunction

	// left-justify a word of nb bits so bit 15 goes out first
	function [15:0] align_f(input [15:0] w, input [4:0] nb);
		begin
			align_f = w << (5'h10 - nb);
		end
	endfunction

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	reg sclk_s1, sclk_s2, sclk_s3; // serial clock in, s3 is edge history
	reg fss_s1, fss_s2, fss_s3; // frame select in
	reg rxd_s1, rxd_s2; // receive data in

	// ------------------------------------------------------------
	// sequencer state
	// ------------------------------------------------------------
	reg [2:0] state_r; // master state
	reg [DW-1:0] hc_r; // half-period countdown
	reg [5:0] e_r; // edge index within word
	reg [1:0] tail_r; // halves spent in tail
	reg [15:0] tx_sh_r; // transmit shifter, MSB out
	reg [15:0] rx_sh_r; // receive shifter

	wire cw = (FORMAT == `SSFS_FMT_CW);
	wire pol = cw ? 1'b0 : CLOCK_POLARITY_BIT; // control word idles low
	wire cpha = cw ? 1'b0 : CLOCK_PHASE_BIT;
	wire [4:0] nbits = {1'b0, DATA_SIZE} + 5'h1; // data size 3..15 gives 4..16
	wire [4:0] txbits = cw ? `SSFS_CW_CTRL_BITS : nbits;
	wire [5:0] e_last = cw ? {nbits, 1'b0} + 6'h11 : {nbits, 1'b0} - 6'h1;
	// limitation: receive bits reach rxd_s2 two cycles late, so HALF_DIV must be 2 or more
	wire tick = (hc_r == {DW{1'b0}});
	wire [15:0] rx_new = {rx_sh_r[14:0], rxd_s2};

	// buffer drain side
	wire [15:0] f_data;
	wire f_valid;
	wire [15:0] f_word = align_f(f_data, txbits);
	wire [15:0] s_word = align_f(f_data, nbits); // slave word, always data sized

	// slave edge detect on synchronised pins only
	wire s_edge = sclk_s2 ^ sclk_s3;
	wire s_fall = fss_s3 & ~fss_s2;
	wire s_act = ENABLE & !MASTER & !fss_s2;
	wire s_load = s_act & (s_fall | (s_edge & !cw & (e_r == e_last)));

	// master decisions
	wire m_start = ENABLE & MASTER & (state_r == `SSFS_ST_IDLE) & f_valid;
	wire m_last = (state_r == `SSFS_ST_SHIFT) & tick & (e_r == e_last);
	wire m_reload = m_last & ENABLE & f_valid & (cw | cpha);
	wire pop = f_valid & (MASTER ? (m_start | m_reload) : s_load);

	// edge roles for the edge now being made or seen
	wire slv = !MASTER;
	wire e_cap = cap_f(cw, cpha, slv, e_r);
	wire e_lau = lau_f(cw, cpha, slv, e_r, nbits);

	ssfs_fifo #(
		.W(`SSFS_WORD_W),
		.D(`SSFS_FIFO_DEPTH),
		.AW(`SSFS_FIFO_AW)
	) u_txq (
		.clk(CLK),
		.nrst(NRST),
		.in_data(TX_DATA),
		.in_valid(TX_VALID),
		.in_ready_r(TX_READY),
		.out_data(f_data),
		.out_valid(f_valid),
		.out_ready(pop)
	);

	// ------------------------------------------------------------
	// two-flop synchronisers for every pin from the far side
	// ------------------------------------------------------------
	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_s3 <= 1'b0;
			fss_s1 <= 1'b1;
			fss_s2 <= 1'b1;
			fss_s3 <= 1'b1;
			rxd_s1 <= 1'b0;
			rxd_s2 <= 1'b0;
		end else begin
			sclk_s1 <= SERIAL_CLOCK_LINE_I;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			fss_s1 <= FRAME_SELECT_LINE_I;
			fss_s2 <= fss_s1;
			fss_s3 <= fss_s2;
			rxd_s1 <= RX_DATA_LINE_I;
			rxd_s2 <= rxd_s1;
		end
	end

	// ------------------------------------------------------------
	// frame sequencing, master and slave
	// ------------------------------------------------------------
	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state_r <= `SSFS_ST_IDLE;
			hc_r <= `SSFS_RST_DIV;
			e_r <= 6'h00;
			tail_r <= 2'h0;
			tx_sh_r <= `SSFS_RST_WORD;
			rx_sh_r <= `SSFS_RST_WORD;
			RX_DATA <= `SSFS_RST_WORD;
			RX_VALID <= 1'b0;
			BUSY <= 1'b0;
			SERIAL_CLOCK_LINE_O <= 1'b0;
			SERIAL_CLOCK_LINE_OE <= 1'b0;
			FRAME_SELECT_LINE_O <= 1'b1;
			FRAME_SELECT_LINE_OE <= 1'b0;
			TX_DATA_LINE_O <= 1'b0;
			TX_DATA_LINE_OE <= 1'b0;
		end else begin
			// consumer takes the word; a new push below wins over it
			if (RX_READY) begin
				RX_VALID <= 1'b0;
			end
			SERIAL_CLOCK_LINE_OE <= MASTER;
			FRAME_SELECT_LINE_OE <= MASTER;
			hc_r <= tick ? HALF_DIV : hc_r - 1'b1;
			if (MASTER) begin
				case (state_r)
				`SSFS_ST_IDLE: begin
					// idle levels held every cycle
					SERIAL_CLOCK_LINE_O <= pol;
					FRAME_SELECT_LINE_O <= 1'b1;
					TX_DATA_LINE_O <= 1'b0;
					TX_DATA_LINE_OE <= 1'b0;
					BUSY <= 1'b0;
					e_r <= 6'h00;
					if (m_start) begin
						FRAME_SELECT_LINE_O <= 1'b0;
						TX_DATA_LINE_OE <= 1'b1;
						BUSY <= 1'b1;
						rx_sh_r <= `SSFS_RST_WORD;
						hc_r <= HALF_DIV;
						state_r <= `SSFS_ST_PRE;
						if (cw) begin
							// control MSB goes out with the select fall
							TX_DATA_LINE_O <= f_word[15];
							tx_sh_r <= {f_word[14:0], 1'b0};
						end else begin
							tx_sh_r <= f_word;
						end
					end
				end
				`SSFS_ST_PRE: begin
					// half a period of select low before the first edge in phase 1, a full period in phase 0
					if (tick) begin
						state_r <= `SSFS_ST_SHIFT;
						if (!cw) begin
							TX_DATA_LINE_O <= tx_sh_r[15];
							tx_sh_r <= {tx_sh_r[14:0], 1'b0};
						end
						if (cpha) begin
							// phase 1: first edge comes with the data
							SERIAL_CLOCK_LINE_O <= ~SERIAL_CLOCK_LINE_O;
							e_r <= 6'h01;
						end
					end
				end
				`SSFS_ST_SHIFT: begin
					if (tick) begin
						SERIAL_CLOCK_LINE_O <= ~SERIAL_CLOCK_LINE_O;
						e_r <= e_r + 6'h01;
						if (e_cap) begin
							rx_sh_r <= rx_new;
						end
						if (e_lau) begin
							TX_DATA_LINE_O <= tx_sh_r[15];
							tx_sh_r <= {tx_sh_r[14:0], 1'b0};
						end
						if (m_last) begin
							if (m_reload) begin
								// next word rides on without lifting select
								RX_DATA <= e_cap ? rx_new : rx_sh_r;
								RX_VALID <= 1'b1;
								rx_sh_r <= `SSFS_RST_WORD;
								e_r <= 6'h00;
								if (cw) begin
									TX_DATA_LINE_O <= f_word[15];
									tx_sh_r <= {f_word[14:0], 1'b0};
								end else begin
									tx_sh_r <= f_word;
								end
							end else begin
								// buffer empty, enable low or SPI phase 0: close the word
								if (!cw) begin
									RX_DATA <= e_cap ? rx_new : rx_sh_r;
									RX_VALID <= 1'b1;
								end
								if (cw) begin
									rx_sh_r <= e_cap ? rx_new : rx_sh_r;
								end
								tail_r <= 2'h0;
								state_r <= `SSFS_ST_TAIL;
							end
						end
					end
				end
				`SSFS_ST_TAIL: begin
					// one full period after the last capture, then select rises
					if (tick) begin
						tail_r <= tail_r + 2'h1;
						if (tail_r == {1'b0, cpha}) begin
							FRAME_SELECT_LINE_O <= 1'b1;
							TX_DATA_LINE_O <= 1'b0;
							TX_DATA_LINE_OE <= 1'b0;
							state_r <= `SSFS_ST_GAP;
							if (cw) begin
								RX_DATA <= rx_sh_r;
								RX_VALID <= 1'b1;
							end
						end
					end
				end
				`SSFS_ST_GAP: begin
					// select stays high one half period before any restart
					if (tick) begin
						state_r <= `SSFS_ST_IDLE;
					end
				end
				default: begin
					state_r <= `SSFS_ST_IDLE;
				end
				endcase
			end else begin
				// slave: follow the far master on synchronised pins
				state_r <= `SSFS_ST_IDLE;
				FRAME_SELECT_LINE_O <= 1'b1;
				SERIAL_CLOCK_LINE_O <= pol;
				if (!s_act) begin
					TX_DATA_LINE_O <= 1'b0;
					TX_DATA_LINE_OE <= 1'b0;
					BUSY <= 1'b0;
					e_r <= 6'h00;
				end else if (s_fall) begin
					// frame opens: load word, phase 0 shows MSB at once
					BUSY <= 1'b1;
					// control word: reply line stays released while the byte comes in
					TX_DATA_LINE_OE <= !cw;
					rx_sh_r <= `SSFS_RST_WORD;
					e_r <= 6'h00;
					tx_sh_r <= f_valid ? s_word : `SSFS_RST_WORD;
					if (!cw && !cpha) begin
						TX_DATA_LINE_O <= f_valid & s_word[15];
						tx_sh_r <= f_valid ? {s_word[14:0], 1'b0} : `SSFS_RST_WORD;
					end
				end else if (s_edge) begin
					e_r <= e_r + 6'h01;
					if (e_cap) begin
						rx_sh_r <= rx_new;
					end
					if (e_lau) begin
						TX_DATA_LINE_O <= tx_sh_r[15];
						TX_DATA_LINE_OE <= 1'b1;
						tx_sh_r <= {tx_sh_r[14:0], 1'b0};
					end
					if (cw && e_r == `SSFS_CW_LAST_CTRL_EDGE) begin
						RX_DATA <= rx_new;
						RX_VALID <= 1'b1;
					end
					if (!cw && e_r == e_last) begin
						// phase 1 words run back to back under one select
						RX_DATA <= e_cap ? rx_new : rx_sh_r;
						RX_VALID <= 1'b1;
						rx_sh_r <= `SSFS_RST_WORD;
						e_r <= 6'h00;
						tx_sh_r <= f_valid ? align_f(f_data, nbits) : `SSFS_RST_WORD;
					end
				end
			end
		end
	end
endmodule // ssfs_sequencer
`default_nettype wire

/* sim/ssfs_properties.sv */
// Purpose: pin timing checks of the frame sequencer
// Assumes: half period short, first clock edge within 40 cycles
// Notes: sees top ports only, bound below
`timescale 1ns/100ps
`default_nettype none
module ssfs_properties (
	input wire CLK,
	input wire NRST,
	input wire MASTER,
	input wire FORMAT,
	input wire CLOCK_POLARITY_BIT,
	input wire TX_VALID,
	input wire TX_READY,
	input wire RX_VALID,
	input wire RX_READY,
	input wire BUSY,
	input wire SERIAL_CLOCK_LINE_O,
	input wire SERIAL_CLOCK_LINE_OE,
	input wire FRAME_SELECT_LINE_O,
	input wire FRAME_SELECT_LINE_OE,
	input wire TX_DATA_LINE_O,
	input wire TX_DATA_LINE_OE
);
	// ------------------------------------------------
	// idle clock level
	// ------------------------------------------------
	wire idle_lvl = !FORMAT && CLOCK_POLARITY_BIT; // control word idles low
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	a_idle_lines: assert property (!TX_DATA_LINE_OE
		|-> !TX_DATA_LINE_O && (FRAME_SELECT_LINE_O || !MASTER))
		else $error("line levels wrong while undriven");
	a_idle_clock: assert property (MASTER && !BUSY && $past(NRST)
		&& $stable(idle_lvl) && $stable(MASTER) |-> SERIAL_CLOCK_LINE_O == idle_lvl)
		else $error("idle clock level wrong");
	a_pad_enable: assert property ($past(NRST) |->
		SERIAL_CLOCK_LINE_OE == $past(MASTER) && FRAME_SELECT_LINE_OE == $past(MASTER))
		else $error("pad enable does not follow role");
	a_framed_select: assert property (MASTER && TX_DATA_LINE_OE
		|-> !FRAME_SELECT_LINE_O) else $error("data driven outside select");
	// ------------------------------------------------
	// clock moves only inside frames
	// ------------------------------------------------
	a_clock_framed: assert property (MASTER && $past(MASTER) && $past(NRST, 2)
		&& $changed(SERIAL_CLOCK_LINE_O) && idle_lvl == $past(idle_lvl, 2)
		|-> !FRAME_SELECT_LINE_O) else $error("clock toggles outside frame");
	a_rise_idle: assert property ($rose(FRAME_SELECT_LINE_O) && MASTER
		|-> SERIAL_CLOCK_LINE_O == idle_lvl) else $error("select rose mid clock");
	// fixed bound: only valid for small half-period divisors
	a_clock_starts: assert property ($fell(FRAME_SELECT_LINE_O) && MASTER
		|-> ##[1:40] $changed(SERIAL_CLOCK_LINE_O)) else $error("clock never started");
	a_rx_holds: assert property (RX_VALID && !RX_READY |=> RX_VALID)
		else $error("received word lost");
	a_ready_drop: assert property ($fell(TX_READY) |-> $past(TX_VALID))
		else $error("buffer full without write");
endmodule // ssfs_properties
bind ssfs_sequencer ssfs_properties u_props (.CLK(CLK), .NRST(NRST), .MASTER(MASTER),
	.FORMAT(FORMAT), .CLOCK_POLARITY_BIT(CLOCK_POLARITY_BIT), .TX_VALID(TX_VALID),
	.TX_READY(TX_READY), .RX_VALID(RX_VALID), .RX_READY(RX_READY), .BUSY(BUSY),
	.SERIAL_CLOCK_LINE_O(SERIAL_CLOCK_LINE_O), .SERIAL_CLOCK_LINE_OE(SERIAL_CLOCK_LINE_OE),
	.FRAME_SELECT_LINE_O(FRAME_SELECT_LINE_O), .FRAME_SELECT_LINE_OE(FRAME_SELECT_LINE_OE),
	.TX_DATA_LINE_O(TX_DATA_LINE_O), .TX_DATA_LINE_OE(TX_DATA_LINE_OE));
`default_nettype wire

/* sim/ssfs_far_dev.sv */
// Purpose: off-chip serial device facing the sequencer as master
// Assumes: one fixed reply word per frame
// Notes: released line toggles so stale bits never pass
`timescale 1ns/100ps
`default_nettype none
module ssfs_far_dev (
	input wire logic sclk,
	input wire logic fss_n,
	input wire logic mosi,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic cw,
	input wire logic [4:0] nbits,
	input wire logic [15:0] reply,
	output logic miso,
	output logic [15:0] got
);
	logic drv = 1'b0; // line driven
	logic bitv = 1'b0; // driven bit
	logic tog = 1'b0; // released pattern
	int k; // reply bit index
	int r; // capture edges seen
	always #7 tog = ~tog;
	assign miso = drv ? bitv : tog;
	// ------------------------------------------------
	// frame start: phase 0 presents at once
	// ------------------------------------------------
	always @(negedge fss_n) begin
		got = 16'h0000;
		r = 0;
		k = (cpha || cw) ? 0 : nbits - 1;
		drv = !(cpha || cw);
		bitv = reply[k];
	end
	always @(posedge fss_n) drv = 1'b0;
	// capture and launch edges per mode
	always @(sclk) begin
		if (!fss_n) begin
			if (sclk == (cw || cpol == cpha)) begin
				if (!cw || r < 8) got = {got[14:0], mosi};
				r = r + 1;
			end else if (!cw || r >= 9) begin
				k = (k == 0) ? nbits - 1 : k - 1;
				drv = 1'b1;
				bitv = reply[k];
			end
		end
	end
endmodule // ssfs_far_dev
`default_nettype wire

/* sim/tb_ssfs_sequencer.sv */
// Purpose: self-checking bench of the frame sequencer
// Assumes: half period of three system cycles
// Notes: master rows in a table, slave frames hand-written
`timescale 1ns/100ps
`default_nettype none
module tb_ssfs_sequencer;
	typedef struct {logic p, h, f; logic [3:0] s; logic [15:0] w, r; int nw;} ssfs_row_t;
	ssfs_row_t rows[5] = '{'{1'h0, 1'h1, 1'h0, 4'h7, 16'h00A5, 16'h003C, 2},
		'{1'h1, 1'h0, 1'h0, 4'h3, 16'h0009, 16'h0006, 2},
		'{1'h1, 1'h1, 1'h0, 4'hF, 16'hC3A5, 16'h5A0F, 1},
		'{1'h0, 1'h0, 1'h1, 4'h7, 16'h00B4, 16'h00D2, 1},
		'{1'h0, 1'h1, 1'h0, 4'h3, 16'h000A, 16'h0005, 9}};
	logic clk = 1'b0, nrst = 1'b0, en = 1'b0, mst = 1'b1, fmt = 1'b0, pol = 1'b1, pha = 1'b0;
	logic txv = 1'b0, rxr = 1'b0, ext_clk = 1'b0, ext_fss = 1'b1, ext_d = 1'b0;
	logic [3:0] size = 4'h7;
	logic [15:0] txd = 16'h0000, reply = 16'h0000, sw, m;
	wire sclk_o, sclk_oe, fss_o, fss_oe, txl_o, txl_oe, txr, rxv, busy, miso;
	wire [15:0] rxw, got;
	wire sclk = sclk_oe ? sclk_o : ext_clk; // pad level from enabled driver
	wire fss = fss_oe ? fss_o : ext_fss;
	wire rxd = mst ? miso : ext_d;
	int n_errors = 0, num_checks = 0, n_tog = 0, n_rise = 0, i, j, q, nw;
	always #5 clk = ~clk;
	always @(sclk_o) n_tog++;
	always @(posedge fss_o) n_rise++;
	// three-cycle half period: returned bits need two synchroniser cycles to land
	ssfs_sequencer u_dut (.CLK(clk), .NRST(nrst), .ENABLE(en), .MASTER(mst), .FORMAT(fmt),
		.CLOCK_POLARITY_BIT(pol), .CLOCK_PHASE_BIT(pha), .DATA_SIZE(size), .HALF_DIV(8'h02),
		.TX_DATA(txd), .TX_VALID(txv), .TX_READY(txr), .RX_DATA(rxw), .RX_VALID(rxv),
		.RX_READY(rxr), .BUSY(busy), .SERIAL_CLOCK_LINE_I(sclk), .SERIAL_CLOCK_LINE_O(sclk_o),
		.SERIAL_CLOCK_LINE_OE(sclk_oe), .FRAME_SELECT_LINE_I(fss), .FRAME_SELECT_LINE_O(fss_o),
		.FRAME_SELECT_LINE_OE(fss_oe), .TX_DATA_LINE_O(txl_o), .TX_DATA_LINE_OE(txl_oe),
		.RX_DATA_LINE_I(rxd));
	ssfs_far_dev u_far (.sclk(sclk_o), .fss_n(fss_o), .mosi(txl_o), .cpol(pol), .cpha(pha),
		.cw(fmt), .nbits({1'h0, size} + 5'h01), .reply(reply), .miso(miso), .got(got));
	// ------------------------------------------------
	// compare, verdict, bounded wait
	// ------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// busy stays high across the gap between queued words, so wait for a quiet spell
	task automatic wait_quiet;
		q = 0;
		for (j = 0; j < 4000 && q < 10; j++) begin
			@(negedge clk);
			q = (busy === 1'b0) ? q + 1 : 0;
		end
		if (q < 10) begin
			n_errors++;
			finish_test;
		end
	endtask
	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial begin
		repeat (8) @(negedge clk);
		check({fss_o, txl_o, txl_oe, busy, txr}, 16'h0010);
		nrst = 1'b1;
		repeat (2) @(negedge clk);
		check({sclk_o, sclk_oe, fss_o}, 16'h0007);
		for (i = 0; i < 5; i++) begin
			{pol, pha, fmt, size, reply} = {rows[i].p, rows[i].h, rows[i].f, rows[i].s, rows[i].r};
			repeat (2) @(negedge clk);
			n_tog = 0;
			n_rise = 0;
			txv = 1'b1;
			txd = rows[i].w;
			repeat (rows[i].nw) @(negedge clk);
			txv = 1'b0;
			nw = (rows[i].nw > 8) ? 8 : rows[i].nw;
			if (rows[i].nw > 8) check(txr, 16'h0000); // ninth write refused
			en = 1'b1;
			repeat (4) @(negedge clk);
			wait_quiet;
			en = 1'b0;
			m = fmt ? 16'h00FF : 16'hFFFF >> (15 - size);
			check(n_tog[15:0], fmt ? 2 * (10 + size) : 2 * (size + 1) * nw);
			check(n_rise[15:0], (pha | fmt) ? 1 : nw);
			check(got & m, txd & m);
			check(rxw, reply & (16'hFFFF >> (15 - size)));
			check(rxv, 16'h0001);
			rxr = 1'b1;
			@(negedge clk);
			rxr = 1'b0;
			@(negedge clk);
			check(rxv, 16'h0000);
		end
		// slave frame, bench is master on a 160 ns link clock
		mst = 1'b0;
		{pol, pha, size, reply} = {1'b0, 1'b1, 4'h7, 16'h005B};
		txv = 1'b1;
		txd = 16'h0096;
		@(negedge clk);
		txv = 1'b0;
		en = 1'b1;
		check(sclk_oe, 16'h0000);
		#3 ext_fss = 1'b0;
		#80;
		for (i = 7; i >= 0; i--) begin
			ext_clk = 1'b1;
			ext_d = reply[i];
			#80;
			ext_clk = 1'b0;
			sw = {sw[14:0], txl_o};
			#80;
		end
		ext_fss = 1'b1;
		repeat (6) @(negedge clk);
		check(sw & 16'h00FF, 16'h0096);
		check(rxw, 16'h005B);
		// control-word slave: bench is far master, select two periods ahead
		fmt = 1'b1;
		reply = 16'h00A6;
		txv = 1'b1;
		txd = 16'h003C;
		@(negedge clk);
		txv = 1'b0;
		#3 ext_fss = 1'b0;
		ext_d = reply[7];
		#320;
		for (i = 0; i < 17; i++) begin
			ext_clk = 1'b1;
			if (i > 8) sw = {sw[14:0], txl_o};
			if (i == 3) check(txl_oe, 16'h0000);
			#80;
			ext_clk = 1'b0;
			ext_d = (i < 7) ? reply[6 - i] : 1'b0;
			#80;
		end
		ext_fss = 1'b1;
		repeat (6) @(negedge clk);
		check(rxw, 16'h00A6);
		check(sw & 16'h00FF, 16'h003C);
		// reset in mid-run clears the unread received word and idles the pins
		nrst = 1'b0;
		@(negedge clk);
		check({fss_o, txl_oe, busy, rxv}, 16'h0008);
		nrst = 1'b1;
		repeat (2) @(negedge clk);
		check({sclk_oe, fss_oe, fss_o}, 16'h0001);
		finish_test;
	end
endmodule // tb_ssfs_sequencer
`default_nettype wire
